/* File: src/pmt_pkg.sv */
/*
 Constants, register map and field layout of the period match timer.
 Assumes a single 100 MHz clock and a plain strobe register port.
*/
package pmt_pkg;
    localparam logic [7:0] ADDR_IRQ_CTRL = 8'h0b;
    localparam logic [7:0] ADDR_FLAGS    = 8'h0c;
    localparam logic [7:0] ADDR_COUNT    = 8'h11;
    localparam logic [7:0] ADDR_CTRL     = 8'h12;
    localparam logic [7:0] ADDR_ENABLES  = 8'h8c;
    localparam logic [7:0] ADDR_PERIOD   = 8'h92;
    localparam logic [7:0] PERIOD_RST    = 8'hff;
    localparam logic [7:0] ZERO8         = 8'h00;
    localparam logic [7:0] CTRL_MASK     = 8'h7f;
    localparam int PRE_LSB  = 0;
    localparam int PRE_MSB  = 1;
    localparam int RUN_BIT  = 2;
    localparam int POST_LSB = 3;
    localparam int POST_MSB = 6;
    localparam int MATCH_FLAG_BIT = 1;
    localparam int GLOBAL_EN_BIT = 7;
    localparam int PERIPH_EN_BIT = 6;
    localparam int INSTR_DIV = 4;
    localparam logic [3:0] PRE_TC_4  = 4'h3;
    localparam logic [3:0] PRE_TC_16 = 4'hf;
    localparam logic [3:0] PRE_TC_1  = 4'h0;
endpackage

/* File: src/pmt_if.sv */
/*
 Internal carrier between the timer core and the prescaler.
 Assumes both ends run on the one system clock.
*/
`timescale 1ns/1ps
interface pmt_if;
    logic       tick;
    logic       run;
    logic [1:0] pre_sel;
    logic       clr;
    logic       pre_pulse;
    modport core (output tick, output run, output pre_sel, output clr, input pre_pulse);
    modport pre  (input tick, input run, input pre_sel, input clr, output pre_pulse);
endinterface

/* File: src/pmt_prescaler.sv */
/*
 Hidden prescale counter fed by the instruction tick.
 Assumes a synchronous clear from the core on count and control writes and reset.
*/
`timescale 1ns/1ps
module pmt_prescaler (
    input  wire logic clk_in,
    input  wire logic rst_in,
    pmt_if.pre        bus
);
    logic [3:0] cnt_ff;
    logic [3:0] tc;

    always_comb begin
        tc = pmt_pkg::PRE_TC_16;
        if (bus.pre_sel == 2'h0) begin
            tc = pmt_pkg::PRE_TC_1;
        end else if (bus.pre_sel == 2'h1) begin
            tc = pmt_pkg::PRE_TC_4;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || bus.clr) begin
            cnt_ff        <= 4'h0;
            bus.pre_pulse <= 1'b0;
        end else if (bus.run && bus.tick) begin
            bus.pre_pulse <= (cnt_ff >= tc);
            cnt_ff        <= (cnt_ff >= tc) ? 4'h0 : cnt_ff + 4'h1;
        end else begin
            bus.pre_pulse <= 1'b0;
        end
    end
endmodule

/* File: src/pmt_timer.sv */
/*
 Period match timer: instruction clock divider, counter, period compare,
 postscaler, flag and enable registers, interrupt and serial/PWM outputs.
 Assumes a register master that follows the plain strobe protocol.
*/
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module pmt_timer (
    input  wire logic       MCLK_IN,
    input  wire logic       SYS_RST_IN,
    input  wire logic [7:0] ADDR_IN,
    input  wire logic [7:0] WDATA_IN,
    input  wire logic       WR_IN,
    input  wire logic       RD_IN,
    output logic      [7:0] RDATA_OUT,
    output logic            IRQ_OUT,
    output logic            MATCH_OUT,
    output logic      [7:0] COUNT_OUT
);
    pmt_if bus ();

    logic [1:0] div_ff;
    logic       tick_ff;
    logic [7:0] count_ff;
    logic [7:0] period_ff;
    logic [6:0] ctrl_ff;
    logic [3:0] post_ff;
    logic [7:0] flags_ff;
    logic [7:0] enables_ff;
    logic [7:0] irqctl_ff;
    logic       wr_count;
    logic       wr_ctrl;
    logic       match;
    logic       pulse;
    logic       wr_flags;
    logic       post_done;
    logic [7:0] nxt_rdata;

    assign wr_count  = WR_IN && (ADDR_IN == pmt_pkg::ADDR_COUNT);
    assign wr_ctrl   = WR_IN && (ADDR_IN == pmt_pkg::ADDR_CTRL);
    // A scaler clear swallows a pulse already in flight
    assign pulse     = bus.pre_pulse && !bus.clr;
    assign wr_flags  = WR_IN && (ADDR_IN == pmt_pkg::ADDR_FLAGS);
    assign match     = pulse && (count_ff == period_ff);
    assign post_done = match && (post_ff == ctrl_ff[pmt_pkg::POST_MSB:pmt_pkg::POST_LSB]);

    assign bus.tick    = tick_ff;
    assign bus.run     = ctrl_ff[pmt_pkg::RUN_BIT];
    assign bus.pre_sel = ctrl_ff[pmt_pkg::PRE_MSB:pmt_pkg::PRE_LSB];
    assign bus.clr     = wr_count || wr_ctrl;

    pmt_prescaler u_pre (
        .clk_in (MCLK_IN),
        .rst_in (SYS_RST_IN),
        .bus    (bus)
    );

    // Instruction clock is one system cycle in four
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            div_ff  <= 2'h0;
            tick_ff <= 1'b0;
        end else begin
            div_ff  <= div_ff + 2'h1;
            tick_ff <= (div_ff == 2'(pmt_pkg::INSTR_DIV - 1));
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            count_ff <= pmt_pkg::ZERO8;
        end else if (wr_count) begin
            count_ff <= WDATA_IN;
        end else if (pulse) begin
            count_ff <= match ? pmt_pkg::ZERO8 : count_ff + 8'h01;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            period_ff <= pmt_pkg::PERIOD_RST;
        end else if (WR_IN && (ADDR_IN == pmt_pkg::ADDR_PERIOD)) begin
            period_ff <= WDATA_IN;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            ctrl_ff <= 7'h00;
        end else if (wr_ctrl) begin
            ctrl_ff <= WDATA_IN[pmt_pkg::POST_MSB:pmt_pkg::PRE_LSB];
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN || bus.clr) begin
            post_ff <= 4'h0;
        end else if (match) begin
            post_ff <= post_done ? 4'h0 : post_ff + 4'h1;
        end
    end

    // Hardware set wins over a software write in the same cycle
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            flags_ff <= pmt_pkg::ZERO8;
        end else begin
            // Write one to clear
            if (wr_flags) begin
                flags_ff <= flags_ff & ~WDATA_IN;
            end
            if (post_done) begin
                flags_ff[pmt_pkg::MATCH_FLAG_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            enables_ff <= pmt_pkg::ZERO8;
            irqctl_ff  <= pmt_pkg::ZERO8;
        end else begin
            if (WR_IN && (ADDR_IN == pmt_pkg::ADDR_ENABLES)) begin
                enables_ff <= WDATA_IN;
            end
            if (WR_IN && (ADDR_IN == pmt_pkg::ADDR_IRQ_CTRL)) begin
                irqctl_ff <= WDATA_IN;
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= |(flags_ff & enables_ff) && irqctl_ff[pmt_pkg::PERIPH_EN_BIT]
                       && irqctl_ff[pmt_pkg::GLOBAL_EN_BIT];
        end
    end

    // Serial port and PWM time base
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            MATCH_OUT <= 1'b0;
            COUNT_OUT <= pmt_pkg::ZERO8;
        end else begin
            MATCH_OUT <= match;
            COUNT_OUT <= count_ff;
        end
    end

    always_comb begin
        nxt_rdata = pmt_pkg::ZERO8;
        case (ADDR_IN)
            pmt_pkg::ADDR_IRQ_CTRL: nxt_rdata = irqctl_ff;
            pmt_pkg::ADDR_FLAGS:    nxt_rdata = flags_ff;
            pmt_pkg::ADDR_COUNT:    nxt_rdata = count_ff;
            pmt_pkg::ADDR_CTRL:     nxt_rdata = {1'b0, ctrl_ff};
            pmt_pkg::ADDR_ENABLES:  nxt_rdata = enables_ff;
            pmt_pkg::ADDR_PERIOD:   nxt_rdata = period_ff;
            default:                nxt_rdata = pmt_pkg::ZERO8;
        endcase
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            RDATA_OUT <= pmt_pkg::ZERO8;
        end else begin
            RDATA_OUT <= RD_IN ? nxt_rdata : pmt_pkg::ZERO8;
        end
    end

    property p_period_wrap;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (match && !wr_count) |=> (count_ff == pmt_pkg::ZERO8);
    endproperty
    a_period_wrap: assert property (p_period_wrap) else $error("no wrap");

    property p_off_holds;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (!bus.run && !WR_IN) |=> $stable(count_ff);
    endproperty
    a_off_holds: assert property (p_off_holds) else $error("count moved while off");

    property p_ctrl_keeps_count;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (wr_ctrl) |=> (count_ff == $past(count_ff) && post_ff == 4'h0);
    endproperty
    a_ctrl_keeps_count: assert property (p_ctrl_keeps_count) else $error("ctrl write");

    property p_flag_set;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        post_done |=> flags_ff[pmt_pkg::MATCH_FLAG_BIT];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_match_out;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        match |=> MATCH_OUT;
    endproperty
    a_match_out: assert property (p_match_out) else $error("match not exported");

    property p_ctrl_bit7;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (RD_IN && ADDR_IN == pmt_pkg::ADDR_CTRL) |=> !RDATA_OUT[7];
    endproperty
    a_ctrl_bit7: assert property (p_ctrl_bit7) else $error("bit 7 set");

    property p_post_range;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        post_ff <= ctrl_ff[pmt_pkg::POST_MSB:pmt_pkg::POST_LSB] || $past(wr_ctrl);
    endproperty
    a_post_range: assert property (p_post_range) else $error("postscaler overrun");

    property p_pre_div1;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (bus.run && bus.pre_sel == 2'h0 && tick_ff && !bus.clr) |=> bus.pre_pulse;
    endproperty
    a_pre_div1: assert property (p_pre_div1) else $error("prescale 1 missed");

    property p_irq;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (flags_ff == pmt_pkg::ZERO8) |=> !IRQ_OUT;
    endproperty
    a_irq: assert property (p_irq) else $error("spurious irq");

    sequence s_ctrl_write;
        wr_ctrl;
    endsequence

    sequence s_scalers_idle;
        (post_ff == 4'h0) && !bus.pre_pulse;
    endsequence

    sequence s_tick_gap;
        (!tick_ff) [*3] ##1 tick_ff;
    endsequence

    property p_ctrl_clears;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        s_ctrl_write |=> s_scalers_idle;
    endproperty
    a_ctrl_clears: assert property (p_ctrl_clears) else $error("ctrl clear");

    property p_count_clears;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        wr_count |=> s_scalers_idle;
    endproperty
    a_count_clears: assert property (p_count_clears) else $error("count clear");

    property p_count_write;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        wr_count |=> (count_ff == $past(WDATA_IN));
    endproperty
    a_count_write: assert property (p_count_write) else $error("count write");

    property p_period_write;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (WR_IN && ADDR_IN == pmt_pkg::ADDR_PERIOD) |=> (period_ff == $past(WDATA_IN));
    endproperty
    a_period_write: assert property (p_period_write) else $error("period write");

    property p_ctrl_write;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        wr_ctrl |=> (ctrl_ff == $past(WDATA_IN[pmt_pkg::POST_MSB:pmt_pkg::PRE_LSB]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("ctrl write data");

    property p_count_step;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (pulse && !match && !wr_count) |=> (count_ff == $past(count_ff) + 8'h01);
    endproperty
    a_count_step: assert property (p_count_step) else $error("count step");

    property p_count_still;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (!pulse && !wr_count) |=> $stable(count_ff);
    endproperty
    a_count_still: assert property (p_count_still) else $error("count drift");

    property p_tick_period;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        tick_ff |=> s_tick_gap;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick spacing");

    property p_off_no_pulse;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        !bus.run |=> !bus.pre_pulse;
    endproperty
    a_off_no_pulse: assert property (p_off_no_pulse) else $error("pulse while off");

    property p_pulse_on_tick;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        bus.pre_pulse |-> $past(tick_ff);
    endproperty
    a_pulse_on_tick: assert property (p_pulse_on_tick) else $error("pulse off tick");

    property p_post_hold;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (!match && !bus.clr) |=> $stable(post_ff);
    endproperty
    a_post_hold: assert property (p_post_hold) else $error("postscaler drift");

    property p_post_step;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (match && !post_done) |=> (post_ff == $past(post_ff) + 4'h1);
    endproperty
    a_post_step: assert property (p_post_step) else $error("postscaler step");

    property p_irq_on;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (|(flags_ff & enables_ff) && irqctl_ff[pmt_pkg::GLOBAL_EN_BIT]
            && irqctl_ff[pmt_pkg::PERIPH_EN_BIT]) |=> IRQ_OUT;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq missing");

    property p_count_out;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        1'b1 |=> (COUNT_OUT == $past(count_ff));
    endproperty
    a_count_out: assert property (p_count_out) else $error("count copy");

    property p_match_single;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        MATCH_OUT |=> !MATCH_OUT;
    endproperty
    a_match_single: assert property (p_match_single) else $error("match too long");

    property p_match_quiet;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        !match |=> !MATCH_OUT;
    endproperty
    a_match_quiet: assert property (p_match_quiet) else $error("stray match");

    property p_flag_hold;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (!post_done && !wr_flags) |=> $stable(flags_ff);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag drift");

    property p_flag_w1c;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        (wr_flags && !post_done) |=> (flags_ff == ($past(flags_ff) & ~$past(WDATA_IN)));
    endproperty
    a_flag_w1c: assert property (p_flag_w1c) else $error("flag clear");

    property p_read_idle;
        @(posedge MCLK_IN) disable iff (SYS_RST_IN)
        !RD_IN |=> (RDATA_OUT == pmt_pkg::ZERO8);
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data idle");
endmodule

/* File: tb/tb.sv */
/*
 Self-checking bench for the period match timer top module.
 Assumes the strobe register port and the package register map.
*/
`timescale 1ns/1ps
module tb;
    logic       MCLK_IN    = 1'b0;
    logic       SYS_RST_IN = 1'b1;
    logic [7:0] ADDR_IN    = 8'h00;
    logic [7:0] WDATA_IN   = 8'h00;
    logic       WR_IN      = 1'b0;
    logic       RD_IN      = 1'b0;
    logic [7:0] RDATA_OUT;
    logic       IRQ_OUT;
    logic       MATCH_OUT;
    logic [7:0] COUNT_OUT;
    int         error_cnt  = 0;
    int         cmp_count  = 0;
    logic [7:0] d;
    int         n;
    int         m;
    logic [7:0] ra [6] = '{8'h0b, 8'h0c, 8'h11, 8'h12, 8'h8c, 8'h92};
    logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff};

    pmt_timer i_dut (
        .MCLK_IN    (MCLK_IN),
        .SYS_RST_IN (SYS_RST_IN),
        .ADDR_IN    (ADDR_IN),
        .WDATA_IN   (WDATA_IN),
        .WR_IN      (WR_IN),
        .RD_IN      (RD_IN),
        .RDATA_OUT  (RDATA_OUT),
        .IRQ_OUT    (IRQ_OUT),
        .MATCH_OUT  (MATCH_OUT),
        .COUNT_OUT  (COUNT_OUT)
    );

    always #5 MCLK_IN = ~MCLK_IN;

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chkn(input string what, input int exp, input int got);
        cmp_count++;
        if (got != exp) begin
            error_cnt++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge MCLK_IN);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge MCLK_IN);
        ADDR_IN  <= a;
        WDATA_IN <= v;
        WR_IN    <= 1'b1;
        @(posedge MCLK_IN);
        WR_IN    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge MCLK_IN);
        ADDR_IN <= a;
        RD_IN   <= 1'b1;
        @(posedge MCLK_IN);
        RD_IN   <= 1'b0;
        #1;
        v = RDATA_OUT;
    endtask

    // Cycles until the next match pulse, bounded
    task automatic wait_match(output int k);
        k = 0;
        do begin
            cyc(1);
            k++;
        end while (MATCH_OUT !== 1'b1 && k < 5000);
    endtask

    initial begin
        #500000;
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(posedge MCLK_IN);
        SYS_RST_IN <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd(ra[i], d);
            chk8("reset value", rv[i], d);
        end
        rd(8'h20, d);
        chk8("unmapped read", 8'h00, d);
        // Stopped timer holds a written count
        wr(pmt_pkg::ADDR_COUNT, 8'h55);
        cyc(80);
        rd(pmt_pkg::ADDR_COUNT, d);
        chk8("count held", 8'h55, d);
        chk8("count out", 8'h55, COUNT_OUT);
        wr(pmt_pkg::ADDR_CTRL, 8'hff);
        rd(pmt_pkg::ADDR_CTRL, d);
        chk8("control readback", 8'h7f, d);
        rd(pmt_pkg::ADDR_COUNT, d);
        chk8("count after control write", 8'h55, d);
        wr(pmt_pkg::ADDR_CTRL, 8'h00);
        wr(pmt_pkg::ADDR_PERIOD, 8'h02);
        rd(pmt_pkg::ADDR_PERIOD, d);
        chk8("period readback", 8'h02, d);
        // Match spacing for every prescale code
        for (int s = 0; s < 4; s++) begin
            wr(pmt_pkg::ADDR_CTRL, {5'h00, 1'b1, s[1:0]});
            wait_match(n);
            wait_match(n);
            chkn("match interval", 3 * 4 * (s == 0 ? 1 : (s == 1 ? 4 : 16)), n);
        end
        wr(pmt_pkg::ADDR_IRQ_CTRL, 8'hc0);
        wr(pmt_pkg::ADDR_ENABLES, 8'h02);
        // Matches per flag for several postscale codes
        foreach (ra[i]) begin
            n = (i == 0) ? 0 : ((i == 5) ? 15 : i);
            wr(pmt_pkg::ADDR_CTRL, 8'h00);
            wr(pmt_pkg::ADDR_FLAGS, 8'hff);
            wr(pmt_pkg::ADDR_COUNT, 8'h00);
            wr(pmt_pkg::ADDR_CTRL, {1'b0, n[3:0], 1'b1, 2'b00});
            m = 0;
            for (int k = 0; k < 1000 && IRQ_OUT !== 1'b1; k++) begin
                cyc(1);
                if (MATCH_OUT === 1'b1) m++;
            end
            chkn("matches per flag", n + 1, m);
        end
        wr(pmt_pkg::ADDR_CTRL, 8'h00);
        rd(pmt_pkg::ADDR_FLAGS, d);
        chk8("flag set", 8'h02, d);
        wr(pmt_pkg::ADDR_FLAGS, 8'h00);
        rd(pmt_pkg::ADDR_FLAGS, d);
        chk8("flag kept on zero write", 8'h02, d);
        wr(pmt_pkg::ADDR_ENABLES, 8'h00);
        cyc(3);
        chk8("irq masked", 8'h00, {7'h00, IRQ_OUT});
        wr(pmt_pkg::ADDR_ENABLES, 8'h02);
        cyc(3);
        chk8("irq unmasked", 8'h01, {7'h00, IRQ_OUT});
        wr(pmt_pkg::ADDR_FLAGS, 8'h02);
        cyc(3);
        chk8("irq cleared", 8'h00, {7'h00, IRQ_OUT});
        tally_and_finish();
    end
endmodule
